//--- pkg/static_mem_ctrl_pkg.sv
// constants for the static memory controller configuration block
// assumes a byte-addressed register port, one aligned word per register
package static_mem_ctrl_pkg;
  localparam int ADDR_W = 8;
  localparam int NUM_CS = 4;
  localparam int CS_W = 2;
  // per chip select: base = cs << CS_STRIDE_SH, then word offsets below
  localparam int CS_STRIDE_SH = 4;
  localparam logic [1:0] WORD_SETUP = 2'h0;
  localparam logic [1:0] WORD_PULSE = 2'h1;
  localparam logic [1:0] WORD_CYCLE = 2'h2;
  localparam logic [1:0] WORD_MODE = 2'h3;
  localparam logic [ADDR_W-1:0] CS_AREA_END = 8'h40;
  localparam logic [ADDR_W-1:0] OFS_SCRAMBLE_MODE = 8'h80;
  localparam logic [ADDR_W-1:0] OFS_KEY_ONE = 8'h84;
  localparam logic [ADDR_W-1:0] OFS_KEY_TWO = 8'h88;
  localparam logic [ADDR_W-1:0] OFS_WP_MODE = 8'he4;
  localparam logic [ADDR_W-1:0] OFS_WP_STATUS = 8'he8;
  // implemented bits; reserved bits read as zero
  localparam logic [31:0] SETUP_MASK = 32'h3f3f_3f3f;
  localparam logic [31:0] PULSE_MASK = 32'h7f7f_7f7f;
  localparam logic [31:0] CYCLE_MASK = 32'h01ff_01ff;
  localparam logic [31:0] MODE_MASK = 32'h311f_3033;
  localparam logic [31:0] SCRAMBLE_MODE_MASK = 32'h000f_0001;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  // mode register fields
  localparam int MODE_READ_CTRL = 0;
  localparam int MODE_WRITE_CTRL = 1;
  localparam int MODE_WIDTH_LSB = 12;
  localparam int MODE_FLOAT_LSB = 16;
  localparam int MODE_FLOAT_OPT = 20;
  localparam int MODE_PAGE_EN = 24;
  localparam int MODE_PAGE_SIZE_LSB = 28;
  localparam int FLOAT_W = 4;
  // setup register field positions, 6 bits each
  localparam int SETUP_WE_LSB = 0;
  localparam int SETUP_CS_WR_LSB = 8;
  localparam int SETUP_RD_LSB = 16;
  localparam int SETUP_CS_RD_LSB = 24;
  localparam logic [7:0] SETUP_HIGH_WEIGHT = 8'h80;
  // scramble mode fields
  localparam int SCR_GLOBAL_BIT = 0;
  localparam int SCR_CS_LSB = 16;
  // write protection
  localparam int WP_ENABLE_BIT = 0;
  localparam int WP_PWD_LSB = 8;
  localparam logic [23:0] WP_PASSWORD = 24'h534d43;
  localparam int WP_FLAG_BIT = 0;
  localparam int WP_SRC_LSB = 8;
  // data bus width codes and widths in bytes
  localparam logic [1:0] WIDTH_8 = 2'h0;
  localparam logic [1:0] WIDTH_16 = 2'h1;
  localparam logic [1:0] WIDTH_32 = 2'h2;
  localparam logic [2:0] BYTES_1 = 3'h1;
  localparam logic [2:0] BYTES_2 = 3'h2;
  localparam logic [2:0] BYTES_4 = 3'h4;
  localparam logic [5:0] PAGE_BASE_BYTES = 6'h04;
endpackage : static_mem_ctrl_pkg

//--- hw/float_turnaround.sv
// bus turnaround counter: loaded when the strobe that controls the read rises (read strobe or chip select), counts down to zero
// assumes load_val already holds the float count plus the turnaround cycle
`timescale 1ns/1ns
module float_turnaround
  import static_mem_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [FLOAT_W:0] load_val,
  input wire logic [CS_W-1:0] load_cs,
  output logic [FLOAT_W:0] count_r,
  output logic [CS_W-1:0] owner_cs_r
);
  typedef struct packed {
    logic [FLOAT_W:0] count;
    logic [CS_W-1:0] owner;
  } turn_t;
  turn_t s_r;
  turn_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (load) begin
      s_nxt.count = load_val;
      s_nxt.owner = load_cs;
    end else if (s_r.count != '0) begin
      s_nxt.count = s_r.count - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign count_r = s_r.count;
  assign owner_cs_r = s_r.owner;
endmodule : float_turnaround

//--- hw/data_scrambler.sv
// registered data scrambler; the same operation scrambles and unscrambles
// assumes keys are stable while data flows
`timescale 1ns/1ns
module data_scrambler
  import static_mem_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  input wire logic [31:0] in_data,
  input wire logic [4:0] in_addr,
  input wire logic enable,
  input wire logic [31:0] key_one,
  input wire logic [31:0] key_two,
  output logic out_valid_r,
  output logic [31:0] out_data_r
);
  typedef struct packed {
    logic valid;
    logic [31:0] data;
  } scr_t;
  scr_t s_r;
  scr_t s_nxt;

  function automatic logic [31:0] rotl(input logic [31:0] v, input logic [4:0] n);
    logic [63:0] d;
    d = {v, v} << n;
    return d[63:32];
  endfunction : rotl

  always_comb begin
    s_nxt.valid = in_valid;
    s_nxt.data = in_data;
    if (enable) begin
      s_nxt.data = in_data ^ key_one ^ rotl(key_two, in_addr); // R11
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign out_valid_r = s_r.valid;
  assign out_data_r = s_r.data;
endmodule : data_scrambler

//--- hw/static_mem_cfg.sv
// static memory controller configuration, turnaround gating, scrambling and
// write protection; the access sequencer sits outside on the same clock
//
// Summary of operation
// R1: width code 0/1/2 gives 8/16/32 bits
// R2: float count field 0 to 15 cycles
// R3: one extra turnaround cycle after float
// R4: other chip select waits float plus one
// R5: optimize overlaps float with next setup
// R6: no optimize waits full float first
// R7: page enable selects page-mode burst reads
// R8: page size code gives 4..32 bytes
// R9: per chip select scramble enables, bits 16-19
// R10: global scramble enable at bit 0
// R11: scramble uses both keys, reset zero
// R12: protection bit changes only with password
// R13: protection shields setup, pulse, cycle, mode
// R14: wrong password ignored, password reads zero
// R15: violation flag sticky until status read
// R16: violation source holds attempted offset
// R17: status read clears flag and source
// R18: read control bit picks float start strobe
// R19: protected write discarded, flag raised
// R20: keys accept only their first write
`timescale 1ns/1ns
module static_mem_cfg
  import static_mem_ctrl_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic acc_req,
  input wire logic [CS_W-1:0] acc_cs,
  input wire logic acc_write,
  input wire logic read_strobe_rise,
  input wire logic chip_select_rise,
  input wire logic data_valid,
  input wire logic [31:0] data_in,
  input wire logic [4:0] data_addr,
  output logic acc_grant,
  output logic float_busy,
  output logic [2:0] cfg_width_bytes,
  output logic cfg_width_reserved,
  output logic cfg_page_read_enable,
  output logic [5:0] cfg_page_bytes,
  output logic cfg_scramble_on,
  output logic data_out_valid,
  output logic [31:0] data_out
);
  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [NUM_CS-1:0][31:0] setup;
    logic [NUM_CS-1:0][31:0] pulse;
    logic [NUM_CS-1:0][31:0] cycle;
    logic [NUM_CS-1:0][31:0] mode;
    logic [31:0] offchip_scramble;
    logic [31:0] scramble_key_part_one;
    logic [31:0] scramble_key_part_two;
    logic key_one_done;
    logic key_two_done;
    logic protection_enable;
    logic protection_violation_flag;
    logic [15:0] protection_violation_source;
    logic [31:0] rdata;
    logic grant;
    logic [CS_W-1:0] read_cs;
    logic [2:0] width_bytes;
    logic width_reserved;
    logic page_read_enable;
    logic [5:0] page_bytes;
    logic scramble_on;
    logic busy;
  } ctrl_t;

  ctrl_t s_r;
  ctrl_t s_nxt;
  logic rst_n;
  logic [1:0] rst_sync_r;
  logic [FLOAT_W:0] float_count;
  logic [CS_W-1:0] float_owner;
  logic float_load;
  logic [FLOAT_W:0] float_load_val;
  logic cs_area;
  logic [CS_W-1:0] reg_cs;
  logic [1:0] reg_word;
  logic prot_hit;
  logic pwd_ok;
  logic may_start;
  logic [7:0] next_setup;

  ////////////////////////////////////////////////////////////////////////////
  // reset release through two flip-flops
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [2:0] width_decode(input logic [1:0] code);
    case (code)
      WIDTH_8: return BYTES_1; // R1
      WIDTH_16: return BYTES_2; // R1
      WIDTH_32: return BYTES_4; // R1
      default: return BYTES_1;
    endcase
  endfunction : width_decode

  // setup length = 128 * bit5 + bits 4:0
  function automatic logic [7:0] setup_len(input logic [31:0] r, input int lsb);
    logic [5:0] f;
    f = r[lsb +: 6];
    return (f[5] ? SETUP_HIGH_WEIGHT : 8'h00) + {3'h0, f[4:0]};
  endfunction : setup_len

  ////////////////////////////////////////////////////////////////////////////
  assign cs_area = reg_addr < CS_AREA_END;
  assign reg_cs = reg_addr[CS_STRIDE_SH +: CS_W];
  assign reg_word = reg_addr[3:2];
  assign prot_hit = reg_wr && cs_area && s_r.protection_enable; // R13
  assign pwd_ok = reg_wdata[WP_PWD_LSB +: 24] == WP_PASSWORD;

  // float period starts at the rise of the strobe that controls the read
  assign float_load = s_r.mode[s_r.read_cs][MODE_READ_CTRL] ?
                      read_strobe_rise : chip_select_rise; // R18
  assign float_load_val = {1'b0, s_r.mode[s_r.read_cs][MODE_FLOAT_LSB +: FLOAT_W]}
                          + 1'b1; // R2 R3

  always_comb begin
    next_setup = acc_write ?
      (s_r.mode[acc_cs][MODE_WRITE_CTRL] ?
        setup_len(s_r.setup[acc_cs], SETUP_WE_LSB) :
        setup_len(s_r.setup[acc_cs], SETUP_CS_WR_LSB)) :
      (s_r.mode[acc_cs][MODE_READ_CTRL] ?
        setup_len(s_r.setup[acc_cs], SETUP_RD_LSB) :
        setup_len(s_r.setup[acc_cs], SETUP_CS_RD_LSB));
  end

  always_comb begin
    may_start = 1'b0;
    if (float_count == '0) begin
      may_start = 1'b1; // R6
    end else if (acc_cs == float_owner && s_r.mode[acc_cs][MODE_FLOAT_OPT] &&
                 {3'h0, float_count} <= next_setup) begin
      may_start = 1'b1; // R5
    end
    // another chip select always waits out the whole turnaround
    if (acc_cs != float_owner && float_count != '0) begin
      may_start = 1'b0; // R4
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_nxt = s_r;
    s_nxt.rdata = '0;
    s_nxt.grant = acc_req && !s_r.grant && !float_load && may_start;
    if (s_nxt.grant && !acc_write) begin
      s_nxt.read_cs = acc_cs;
    end
    // configuration seen by the sequencer for the requested chip select
    s_nxt.width_bytes = width_decode(s_r.mode[acc_cs][MODE_WIDTH_LSB +: 2]); // R1
    s_nxt.width_reserved = &s_r.mode[acc_cs][MODE_WIDTH_LSB +: 2];
    s_nxt.page_read_enable = s_r.mode[acc_cs][MODE_PAGE_EN]; // R7
    s_nxt.page_bytes = PAGE_BASE_BYTES <<
                       s_r.mode[acc_cs][MODE_PAGE_SIZE_LSB +: 2]; // R8
    s_nxt.scramble_on = s_r.offchip_scramble[SCR_GLOBAL_BIT] &&
                        s_r.offchip_scramble[SCR_CS_LSB + acc_cs]; // R9 R10
    // next turnaround count is nonzero after a load or while above one
    s_nxt.busy = float_load || float_count > {{FLOAT_W{1'b0}}, 1'b1}; // R3

    if (reg_rd) begin
      if (cs_area) begin
        case (reg_word)
          WORD_SETUP: s_nxt.rdata = s_r.setup[reg_cs];
          WORD_PULSE: s_nxt.rdata = s_r.pulse[reg_cs];
          WORD_CYCLE: s_nxt.rdata = s_r.cycle[reg_cs];
          default: s_nxt.rdata = s_r.mode[reg_cs];
        endcase
      end else begin
        case (reg_addr)
          OFS_SCRAMBLE_MODE: s_nxt.rdata = s_r.offchip_scramble;
          OFS_WP_MODE: s_nxt.rdata[WP_ENABLE_BIT] = s_r.protection_enable; // R14
          OFS_WP_STATUS: begin
            s_nxt.rdata[WP_FLAG_BIT] = s_r.protection_violation_flag;
            s_nxt.rdata[WP_SRC_LSB +: 16] = s_r.protection_violation_source;
            s_nxt.protection_violation_flag = 1'b0; // R17
            s_nxt.protection_violation_source = '0; // R17
          end
          default: s_nxt.rdata = '0;
        endcase
      end
    end

    if (reg_wr) begin
      if (cs_area) begin
        if (!s_r.protection_enable) begin
          case (reg_word)
            WORD_SETUP: s_nxt.setup[reg_cs] = reg_wdata & SETUP_MASK;
            WORD_PULSE: s_nxt.pulse[reg_cs] = reg_wdata & PULSE_MASK;
            WORD_CYCLE: s_nxt.cycle[reg_cs] = reg_wdata & CYCLE_MASK;
            default: s_nxt.mode[reg_cs] = reg_wdata & MODE_MASK;
          endcase
        end
      end else begin
        case (reg_addr)
          OFS_SCRAMBLE_MODE: s_nxt.offchip_scramble = reg_wdata & SCRAMBLE_MODE_MASK;
          OFS_KEY_ONE: begin
            if (!s_r.key_one_done) begin
              s_nxt.scramble_key_part_one = reg_wdata; // R11
              s_nxt.key_one_done = 1'b1; // R20
            end
          end
          OFS_KEY_TWO: begin
            if (!s_r.key_two_done) begin
              s_nxt.scramble_key_part_two = reg_wdata; // R11
              s_nxt.key_two_done = 1'b1; // R20
            end
          end
          OFS_WP_MODE: begin
            if (pwd_ok) begin
              s_nxt.protection_enable = reg_wdata[WP_ENABLE_BIT]; // R12 R14
            end
          end
          default: s_nxt.rdata = s_nxt.rdata;
        endcase
      end
    end

    // a violation in the same cycle as a status read survives it
    if (prot_hit) begin
      s_nxt.protection_violation_flag = 1'b1; // R15 R19
      s_nxt.protection_violation_source = {{(16-ADDR_W){1'b0}}, reg_addr}; // R16
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  float_turnaround u_turn (
    .clk(sys_clk),
    .rst_n(rst_n),
    .load(float_load),
    .load_val(float_load_val),
    .load_cs(s_r.read_cs),
    .count_r(float_count),
    .owner_cs_r(float_owner)
  );

  data_scrambler u_scr (
    .clk(sys_clk),
    .rst_n(rst_n),
    .in_valid(data_valid),
    .in_data(data_in),
    .in_addr(data_addr),
    .enable(s_r.scramble_on),
    .key_one(s_r.scramble_key_part_one),
    .key_two(s_r.scramble_key_part_two),
    .out_valid_r(data_out_valid),
    .out_data_r(data_out)
  );

  assign reg_rdata = s_r.rdata;
  assign acc_grant = s_r.grant;
  assign float_busy = s_r.busy;
  assign cfg_width_bytes = s_r.width_bytes;
  assign cfg_width_reserved = s_r.width_reserved;
  assign cfg_page_read_enable = s_r.page_read_enable;
  assign cfg_page_bytes = s_r.page_bytes;
  assign cfg_scramble_on = s_r.scramble_on;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_float_zero_len: assert property (float_load && float_load_val == 5'h01 |=> // R3
    float_count == 5'h01 ##1 float_count == 5'h00)
    else $error("turnaround not one cycle for zero float");
  a_float_full_len: assert property (float_load && float_load_val == 5'h10 |=> // R2
    float_count == 5'h10 ##1 float_count == 5'h0f)
    else $error("float count not loaded with field plus one");
  a_other_cs_wait: assert property (acc_grant && $past(float_count) != '0 |-> // R4
    $past(acc_cs) == $past(float_owner))
    else $error("other chip select started during turnaround");
  a_no_opt_wait: assert property (acc_grant && !$past(s_r.mode[acc_cs][MODE_FLOAT_OPT]) |-> // R6
    $past(float_count) == '0)
    else $error("access started before float ended");
  a_wp_discard: assert property (prot_hit && reg_word == WORD_MODE |=> // R13 R19
    $stable(s_r.mode) && s_r.protection_violation_flag)
    else $error("protected write not discarded");
  a_wp_source: assert property (prot_hit |=> // R16
    s_r.protection_violation_source == {8'h00, $past(reg_addr)})
    else $error("violation source wrong");
  a_bad_pwd: assert property (reg_wr && reg_addr == OFS_WP_MODE && !pwd_ok |=> // R14
    $stable(s_r.protection_enable))
    else $error("protection bit changed without password");
  a_status_clear: assert property (reg_rd && reg_addr == OFS_WP_STATUS && !prot_hit |=> // R17
    !s_r.protection_violation_flag && s_r.protection_violation_source == '0)
    else $error("status read did not clear");
  a_flag_sticky: assert property (s_r.protection_violation_flag && // R15
    !(reg_rd && reg_addr == OFS_WP_STATUS) |=> s_r.protection_violation_flag)
    else $error("violation flag dropped without read");
  a_key_once: assert property (s_r.key_one_done && reg_wr && reg_addr == OFS_KEY_ONE |=> // R20
    $stable(s_r.scramble_key_part_one))
    else $error("key accepted a second write");
  a_pwd_reads_zero: assert property (reg_rd && reg_addr == OFS_WP_MODE |=> // R14
    reg_rdata[31:1] == 31'h0)
    else $error("password field read nonzero");
  a_key_two_once: assert property (s_r.key_two_done && reg_wr && // R20
    reg_addr == OFS_KEY_TWO |=> $stable(s_r.scramble_key_part_two))
    else $error("second key accepted a second write");
  a_pwd_enable: assert property (reg_wr && reg_addr == OFS_WP_MODE && pwd_ok |=> // R12
    s_r.protection_enable == $past(reg_wdata[WP_ENABLE_BIT]))
    else $error("protection bit ignored a correct password");
  a_scr_global_off: assert property (!s_r.offchip_scramble[SCR_GLOBAL_BIT] |=> // R10
    !cfg_scramble_on)
    else $error("scrambling on with global enable off");
  a_width_code: assert property (s_r.mode[acc_cs][MODE_WIDTH_LSB +: 2] == WIDTH_32 |=> // R1
    cfg_width_bytes == BYTES_4)
    else $error("32-bit width code not decoded");
  a_busy_count: assert property (float_busy == (float_count != '0)) // R3
    else $error("busy flag disagrees with turnaround counter");

  c_opt_overlap: cover property (acc_grant && $past(float_count) != '0);
  c_violation: cover property (prot_hit ##[1:20] reg_rd && reg_addr == OFS_WP_STATUS);
  c_wp_on: cover property (reg_wr && reg_addr == OFS_WP_MODE && pwd_ok && reg_wdata[0]);
  c_other_cs_wait: cover property (acc_req && acc_cs != float_owner && float_busy);
  c_key_rewrite: cover property (s_r.key_one_done && reg_wr && reg_addr == OFS_KEY_ONE);
endmodule : static_mem_cfg

//--- bench/static_mem_partner.sv
// far-side static memory model: answers every granted read
// assumes the requester holds acc_cs steady through an access
`timescale 1ns/1ns
module static_mem_partner #(
  parameter int PULSE_CYC = 2,
  parameter logic [31:0] RD_WORD = 32'h5a3c_96e1,
  parameter logic [4:0] RD_ADDR = 5'h03
) (
  input wire logic sys_clk,
  input wire logic acc_grant,
  input wire logic acc_write,
  output logic read_strobe_rise,
  output logic chip_select_rise,
  output logic data_valid,
  output logic [31:0] data_in,
  output logic [4:0] data_addr
);
  int cnt_r = 0;
  initial begin
    read_strobe_rise = 1'b0;
    chip_select_rise = 1'b0;
    data_valid = 1'b0;
    data_in = ~RD_WORD;
    data_addr = ~RD_ADDR;
  end
  always @(posedge sys_clk) begin
    read_strobe_rise <= 1'b0;
    chip_select_rise <= 1'b0;
    data_valid <= 1'b0;
    // released bus: pattern changes every cycle
    data_in <= ~data_in;
    data_addr <= ~data_addr;
    if (acc_grant === 1'b1 && acc_write === 1'b0) begin
      cnt_r <= PULSE_CYC;
    end else if (cnt_r > 0) begin
      cnt_r <= cnt_r - 1;
    end
    if (cnt_r == 1) begin
      read_strobe_rise <= 1'b1;
      chip_select_rise <= 1'b1;
      data_valid <= 1'b1;
      data_in <= RD_WORD;
      data_addr <= RD_ADDR;
    end
  end
endmodule : static_mem_partner

//--- bench/static_mem_cfg_bench.sv
// self-checking bench for the static memory configuration block
// assumes the far-side model answers each granted read
`timescale 1ns/1ns
module static_mem_cfg_bench;
  import static_mem_ctrl_pkg::*;
  localparam logic [31:0] WORD = 32'h5a3c_96e1;
  logic sys_clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0, reg_rdata, data_in, data_out, got_out;
  logic acc_req = 1'b0, acc_write = 1'b0;
  logic [CS_W-1:0] acc_cs = '0;
  logic read_strobe_rise, chip_select_rise, data_valid, acc_grant, float_busy;
  logic cfg_width_reserved, cfg_page_read_enable, cfg_scramble_on, data_out_valid;
  logic [4:0] data_addr;
  logic [2:0] cfg_width_bytes;
  logic [5:0] cfg_page_bytes;
  int num_errors = 0, samples_checked = 0;
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (data_out_valid === 1'b1) got_out <= data_out;
  static_mem_cfg i_static_mem_cfg (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .acc_req(acc_req), .acc_cs(acc_cs), .acc_write(acc_write),
    .read_strobe_rise(read_strobe_rise), .chip_select_rise(chip_select_rise),
    .data_valid(data_valid), .data_in(data_in), .data_addr(data_addr),
    .acc_grant(acc_grant), .float_busy(float_busy), .cfg_width_bytes(cfg_width_bytes),
    .cfg_width_reserved(cfg_width_reserved), .cfg_page_read_enable(cfg_page_read_enable),
    .cfg_page_bytes(cfg_page_bytes), .cfg_scramble_on(cfg_scramble_on),
    .data_out_valid(data_out_valid), .data_out(data_out));
  static_mem_partner #(.RD_WORD(WORD)) i_static_mem_partner (.sys_clk(sys_clk),
    .acc_grant(acc_grant), .acc_write(acc_write), .read_strobe_rise(read_strobe_rise),
    .chip_select_rise(chip_select_rise), .data_valid(data_valid), .data_in(data_in),
    .data_addr(data_addr));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask : rc
  function automatic logic [31:0] mk_mode(input logic [3:0] f, input logic o,
      input logic [1:0] w, input logic pm, input logic [1:0] ps);
    return {2'h0, ps, 3'h0, pm, 3'h0, o, f, 2'h0, w, 10'h0, 2'h1};
  endfunction : mk_mode
  // counts cycles until a grant shows, releasing the request in that cycle
  task automatic grant_wait(output int n, output int busy);
    busy = 0;
    for (n = 0; n < 60 && acc_grant !== 1'b1; n++) begin
      @(posedge sys_clk);
      #1 busy += (float_busy === 1'b1);
    end
    if (n == 60) begin
      num_errors++;
      test_done();
    end
    acc_req <= 1'b0;
  endtask : grant_wait
  task automatic rd_pair(input logic [1:0] a, input logic [1:0] b, output int lat,
      output int busy);
    int i;
    @(posedge sys_clk);
    acc_req <= 1'b1;
    acc_cs <= a;
    grant_wait(lat, busy);
    for (i = 0; i < 20 && read_strobe_rise !== 1'b1; i++) begin
      @(posedge sys_clk);
      #1;
    end
    if (i == 20) begin
      num_errors++;
      test_done();
    end
    acc_req <= 1'b1;
    acc_cs <= b;
    grant_wait(lat, busy);
    repeat (3) @(posedge sys_clk);
  endtask : rd_pair
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [7:0] a[7] = '{8'h0c, 8'h80, 8'h84, 8'h88, 8'he4, 8'he8, 8'hf0};
    foreach (a[i]) rc(a[i], 32'h0);
    $display("reset test done");
  endtask : t_reset
  task automatic t_mode;
    logic [2:0] wb[4] = '{3'h1, 3'h2, 3'h4, 3'h1};
    for (int i = 0; i < 4; i++) begin
      wr(8'h0c, mk_mode(4'h0, 1'b0, i[1:0], 1'b1, i[1:0]));
      repeat (3) @(posedge sys_clk);
      #1 chk({29'h0, cfg_width_bytes}, {29'h0, wb[i]});
      chk({31'h0, cfg_width_reserved}, {31'h0, i == 3});
      chk({26'h0, cfg_page_bytes}, {26'h0, 6'h04 << i});
      chk({31'h0, cfg_page_read_enable}, 32'h1);
    end
    wr(8'h0c, mk_mode(4'h0, 1'b0, 2'h2, 1'b0, 2'h0));
    repeat (3) @(posedge sys_clk);
    #1 chk({31'h0, cfg_page_read_enable}, 32'h0);
    $display("mode test done");
  endtask : t_mode
  task automatic t_float;
    logic [3:0] f[4] = '{4'h0, 4'hf, 4'h3, 4'h3};
    logic o[4] = '{1'b0, 1'b0, 1'b1, 1'b1};
    logic [1:0] b[4] = '{2'h1, 2'h1, 2'h0, 2'h1};
    int lat, busy;
    for (int i = 0; i < 4; i++) begin
      wr(8'h00, 32'h0008_0000);
      wr(8'h0c, mk_mode(f[i], o[i], 2'h2, 1'b0, 2'h0));
      wr(8'h1c, mk_mode(f[i], o[i], 2'h2, 1'b0, 2'h0));
      rd_pair(2'h0, b[i], lat, busy);
      chk(busy, (o[i] && b[i] == 2'h0) ? 2 : f[i] + 1);
      chk(lat, (o[i] && b[i] == 2'h0) ? 2 : f[i] + 3);
    end
    $display("float test done");
  endtask : t_float
  task automatic t_scram;
    logic [31:0] k1 = 32'h1357_9bdf, k2 = 32'h8000_0421;
    int lat, busy;
    wr(8'h84, k1);
    wr(8'h88, k2);
    wr(8'h84, 32'hffff_0000);
    wr(8'h88, 32'h0000_ffff);
    rc(8'h84, 32'h0);
    wr(8'h80, 32'hfff1_0001);
    rc(8'h80, 32'h0001_0001);
    acc_cs <= 2'h1;
    repeat (3) @(posedge sys_clk);
    #1 chk({31'h0, cfg_scramble_on}, 32'h0);
    rd_pair(2'h0, 2'h0, lat, busy);
    #1 chk({31'h0, cfg_scramble_on}, 32'h1);
    chk(got_out, WORD ^ k1 ^ ((k2 << 3) | (k2 >> 29)));
    wr(8'h80, 32'h000f_0000);
    rd_pair(2'h0, 2'h0, lat, busy);
    #1 chk({31'h0, cfg_scramble_on}, 32'h0);
    chk(got_out, WORD);
    $display("scramble test done");
  endtask : t_scram
  task automatic t_protect;
    logic [31:0] v = mk_mode(4'h5, 1'b0, 2'h1, 1'b0, 2'h0);
    wr(8'h1c, v);
    wr(8'he4, 32'h1234_5601);
    rc(8'he4, 32'h0);
    wr(8'he4, {WP_PASSWORD, 8'h01});
    rc(8'he4, 32'h1);
    wr(8'h14, 32'h7f);
    wr(8'h1c, 32'h0);
    wr(8'h80, 32'h0);
    rc(8'h1c, v);
    rc(8'h14, 32'h0);
    rc(8'he8, 32'h0000_1c01);
    rc(8'he8, 32'h0);
    wr(8'he4, {WP_PASSWORD, 8'h00});
    rc(8'he4, 32'h0);
    wr(8'h1c, 32'h0);
    rc(8'h1c, 32'h0);
    rc(8'he8, 32'h0);
    $display("protect test done");
  endtask : t_protect
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    t_reset();
    t_mode();
    t_float();
    t_scram();
    t_protect();
    test_done();
  end
endmodule : static_mem_cfg_bench
